// *** design/block_transfer_engine.sv ***
`timescale 1ns/1ns
//Contract
//- op 0000 host write with raster; 0010 memory copy with raster.
//- op 0100 host write keyed, 0101 copy keyed, no raster.
//- op 0110 pattern fill with raster; 0111 pattern fill keyed.
//- ops 1000, 1001, 1110, 1111 colour-expand monochrome source, no raster.
//- op 1010 blends two memory sources; 1011 blends host and memory.
//- op 1100 solid fill; other codes reserved, host must not use.
//- upper four bits pick raster; 0000 gives zeros, 1111 ones.
//- raster 1100 passes first source; 1110 ORs both sources.
//- raster 0001 to 0110: NOR, ~A&B, ~A, A&~B, ~B, XOR.
//- raster 0111 to 1101: NAND, AND, XNOR, B, ~A|B, A|~B.
//- first source host or memory; second memory only; results to memory.
//- expansion start bit from raster field; 0-15 wide, 0-7 narrow; ops 1110 and 1111 take bit 0 of each memory word instead.
//- busy until done, on control zero bit 4 and status bit 3.
//- completion drives active-low interrupt; cause in interrupt status.
//- sources and destination walked as window-sized rectangles; pattern ops walk the first source as an 8x8 tile.
//- keyed: skip write when source equals background, else write it.
//- expansion: one bit gives foreground, zero gives background colour; ops 1001 and 1111 skip the write on a zero bit instead.
module block_transfer_engine
    import blit_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    // host pixel data
    input wire logic host_bus_16,
    input wire logic host_pix_valid,
    input wire logic [23:0] host_pix_data,
    output logic host_ready_q,
    // display memory
    output logic mem_req_q,
    output mem_cmd_t mem_cmd_q,
    input wire logic mem_ack,
    input wire logic [23:0] mem_rdata,
    // status and interrupt
    output logic [7:0] main_status_q,
    output logic int_n_q
);

    logic [7:0] regs_q [ARRAY_N];
    logic [7:0] ctrl_zero_q;
    logic [7:0] op_ctrl_q;
    logic done_flag_q;
    logic busy_q;
    state_t state_q;
    op_t op_q;
    logic [3:0] rop_q;
    logic [15:0] row_q;
    logic [15:0] col_q;
    logic [23:0] s0_q;
    logic [23:0] s1_q;
    logic [15:0] exp_word_q;
    logic [3:0] exp_bit_q;
    logic exp_have_q;
    logic exp_cur_q;

    block_t src0, src1, dst;
    logic [15:0] win_w, win_h;
    logic [23:0] fg, bg, res, rop_out;
    logic skip, start_hit, start_ok, last_px, take;
    logic [3:0] exp_last;

    function automatic logic [7:0] byte_at(input logic [7:0] ofs);
        logic [7:0] idx;
        idx = ofs - OFS_ARRAY_LO;
        return regs_q[idx[6:0]];
    endfunction : byte_at

    function automatic block_t grp(input logic [7:0] b);
        block_t g;
        g.addr = {byte_at(b + GRP_ADDR + 8'h03), byte_at(b + GRP_ADDR + 8'h02),
                  byte_at(b + GRP_ADDR + 8'h01), byte_at(b + GRP_ADDR)};
        g.width = {byte_at(b + GRP_WIDTH + 8'h01), byte_at(b + GRP_WIDTH)};
        g.x = {byte_at(b + GRP_X + 8'h01), byte_at(b + GRP_X)};
        g.y = {byte_at(b + GRP_Y + 8'h01), byte_at(b + GRP_Y)};
        return g;
    endfunction : grp

    function automatic logic [23:0] colour_at(input logic [7:0] b);
        return {byte_at(b), byte_at(b + 8'h01), byte_at(b + 8'h02)};
    endfunction : colour_at

    // pixel address inside a rectangle
    function automatic logic [31:0] pix_addr(input block_t g,
                                             input logic [15:0] r,
                                             input logic [15:0] c);
        logic [31:0] yy;
        logic [31:0] xx;
        logic [63:0] prod;
        yy = 32'(g.y) + 32'(r);
        xx = 32'(g.x) + 32'(c);
        prod = yy * 32'(g.width);
        return g.addr + prod[31:0] + xx;
    endfunction : pix_addr

    function automatic logic is_valid(input logic [3:0] o);
        return !(o == 4'b0001 || o == 4'b0011 || o == 4'b1101);
    endfunction : is_valid

    function automatic logic host_src(input op_t o);
        return o inside {OP_HOST_ROP, OP_HOST_KEY, OP_HOST_EXP,
                         OP_HOST_EXPK, OP_HOST_BLEND};
    endfunction : host_src

    function automatic logic mem_src(input op_t o);
        return o inside {OP_COPY_ROP, OP_COPY_KEY, OP_PAT_ROP, OP_PAT_KEY,
                         OP_COPY_BLEND, OP_COPY_EXP, OP_COPY_EXPK};
    endfunction : mem_src

    function automatic logic needs_s1(input op_t o);
        return o inside {OP_HOST_ROP, OP_COPY_ROP, OP_PAT_ROP,
                         OP_COPY_BLEND, OP_HOST_BLEND};
    endfunction : needs_s1

    function automatic logic is_exp(input op_t o);
        return o inside {OP_HOST_EXP, OP_HOST_EXPK};
    endfunction : is_exp

    function automatic state_t first_state(input op_t o);
        if (host_src(o)) begin
            return S_HOST;
        end else if (mem_src(o)) begin
            return S_RD0;
        end
        return S_WR;
    endfunction : first_state

    function automatic logic [23:0] blend(input logic [23:0] a,
                                          input logic [23:0] b);
        logic [23:0] r;
        logic [8:0] s;
        r = RST_PIXEL;
        for (int k = 0; k < 3; k++) begin
            s = {1'b0, a[k*8 +: 8]} + {1'b0, b[k*8 +: 8]};
            r[k*8 +: 8] = s[8:1];
        end
        return r;
    endfunction : blend

    raster_unit u_raster (
        .a(s0_q),
        .b(s1_q),
        .code(rop_q),
        .y(rop_out)
    );

    always_comb begin
        src0 = grp(OFS_FIRST_SOURCE);
        src1 = grp(OFS_SECOND_SOURCE);
        dst = grp(OFS_DESTINATION);
        win_w = {byte_at(OFS_WIN_WIDTH + 8'h01), byte_at(OFS_WIN_WIDTH)};
        win_h = {byte_at(OFS_WIN_HEIGHT + 8'h01), byte_at(OFS_WIN_HEIGHT)};
        fg = colour_at(OFS_FG_COLOUR);
        bg = colour_at(OFS_BG_COLOUR);
        exp_last = host_bus_16 ? EXP_LAST_WIDE : EXP_LAST_NARROW;
        start_hit = state_q == S_IDLE && reg_wr && reg_addr == OFS_CTRL_ZERO
                    && reg_wdata[CTRL_BUSY_BIT];
        start_ok = start_hit && is_valid(op_ctrl_q[OP_LSB +: 4])
                   && win_w != 16'h0000 && win_h != 16'h0000;
        last_px = state_q == S_NEXT && col_q + 16'h0001 == win_w
                  && row_q + 16'h0001 == win_h;
        take = state_q == S_HOST && host_ready_q && host_pix_valid;
    end

    always_comb begin
        res = fg;
        skip = 1'b0;
        unique case (op_q)
            OP_HOST_ROP, OP_COPY_ROP, OP_PAT_ROP: res = rop_out;
            OP_HOST_KEY, OP_COPY_KEY, OP_PAT_KEY: begin
                res = s0_q;
                skip = s0_q == bg;
            end
            OP_HOST_EXP, OP_COPY_EXP: res = exp_cur_q ? fg : bg;
            OP_HOST_EXPK, OP_COPY_EXPK: skip = !exp_cur_q;
            OP_COPY_BLEND, OP_HOST_BLEND: res = blend(s0_q, s1_q);
            OP_SOLID: res = fg;
            default: res = fg;
        endcase
    end

    // register storage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ARRAY_N; i++) begin
                regs_q[i] <= RST_BYTE;
            end
            ctrl_zero_q <= RST_BYTE;
            op_ctrl_q <= RST_BYTE;
        end else if (reg_wr) begin
            if (reg_addr == OFS_CTRL_ZERO) begin
                ctrl_zero_q <= reg_wdata;
            end else if (reg_addr == OFS_OP_CTRL) begin
                op_ctrl_q <= reg_wdata;
            end else if (reg_addr >= OFS_ARRAY_LO
                         && reg_addr <= OFS_ARRAY_HI) begin
                regs_q[7'(reg_addr - OFS_ARRAY_LO)] <= reg_wdata;
            end
        end
    end

    // read data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= RST_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == OFS_CTRL_ZERO) begin
                reg_rdata_q <= {ctrl_zero_q[7:5], busy_q, ctrl_zero_q[3:0]};
            end else if (reg_addr == OFS_OP_CTRL) begin
                reg_rdata_q <= op_ctrl_q;
            end else if (reg_addr == OFS_INT_STATUS) begin
                reg_rdata_q <= 8'(done_flag_q) << INT_DONE_BIT;
            end else if (reg_addr >= OFS_ARRAY_LO
                         && reg_addr <= OFS_ARRAY_HI) begin
                reg_rdata_q <= regs_q[7'(reg_addr - OFS_ARRAY_LO)];
            end else begin
                reg_rdata_q <= RST_BYTE;
            end
        end
    end

    // busy, completion flag, interrupt and status
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            done_flag_q <= 1'b0;
            int_n_q <= 1'b1;
            main_status_q <= RST_BYTE;
        end else begin
            busy_q <= start_ok || (busy_q && !last_px);
            main_status_q <= 8'(start_ok || (busy_q && !last_px))
                             << STS_BUSY_BIT;
            // set wins over a write-one clear
            if (last_px || (start_hit && !start_ok)) begin
                done_flag_q <= 1'b1;
                int_n_q <= 1'b0;
            end else if (reg_wr && reg_addr == OFS_INT_STATUS
                         && reg_wdata[INT_DONE_BIT]) begin
                done_flag_q <= 1'b0;
                int_n_q <= 1'b1;
            end
        end
    end

    // host data request
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_ready_q <= 1'b0;
        end else begin
            host_ready_q <= state_q == S_HOST && !take
                            && !(is_exp(op_q) && exp_have_q);
        end
    end

    // block walk
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            op_q <= OP_HOST_ROP;
            rop_q <= 4'h0;
            row_q <= 16'h0000;
            col_q <= 16'h0000;
            s0_q <= RST_PIXEL;
            s1_q <= RST_PIXEL;
            exp_word_q <= 16'h0000;
            exp_bit_q <= 4'h0;
            exp_have_q <= 1'b0;
            exp_cur_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_cmd_q <= '0;
        end else begin
            unique case (state_q)
                S_IDLE: if (start_ok) begin
                    op_q <= op_t'(op_ctrl_q[OP_LSB +: 4]);
                    rop_q <= op_ctrl_q[RASTER_LSB +: 4];
                    exp_bit_q <= op_ctrl_q[RASTER_LSB +: 4];
                    exp_have_q <= 1'b0;
                    row_q <= 16'h0000;
                    col_q <= 16'h0000;
                    state_q <= first_state(op_t'(op_ctrl_q[OP_LSB +: 4]));
                end
                S_HOST: if (is_exp(op_q) && exp_have_q) begin
                    exp_cur_q <= exp_word_q[exp_bit_q];
                    if (exp_bit_q >= exp_last) begin
                        exp_bit_q <= rop_q;
                        exp_have_q <= 1'b0;
                    end else begin
                        exp_bit_q <= exp_bit_q + 4'h1;
                    end
                    state_q <= S_WR;
                end else if (take) begin
                    if (is_exp(op_q)) begin
                        exp_word_q <= host_pix_data[15:0];
                        exp_have_q <= 1'b1;
                    end else begin
                        s0_q <= host_pix_data;
                        state_q <= needs_s1(op_q) ? S_RD1 : S_WR;
                    end
                end
                S_RD0: if (mem_ack) begin
                    mem_req_q <= 1'b0;
                    s0_q <= mem_rdata;
                    exp_cur_q <= mem_rdata[0];
                    state_q <= needs_s1(op_q) ? S_RD1 : S_WR;
                end else if (!mem_req_q) begin
                    mem_req_q <= 1'b1;
                    mem_cmd_q.we <= 1'b0;
                    mem_cmd_q.addr <= op_q inside {OP_PAT_ROP, OP_PAT_KEY} ?
                        pix_addr(src0, {13'h0000, row_q[2:0]},
                                 {13'h0000, col_q[2:0]}) :
                        pix_addr(src0, row_q, col_q);
                end
                S_RD1: if (mem_ack) begin
                    mem_req_q <= 1'b0;
                    s1_q <= mem_rdata;
                    state_q <= S_WR;
                end else if (!mem_req_q) begin
                    mem_req_q <= 1'b1;
                    mem_cmd_q.we <= 1'b0;
                    mem_cmd_q.addr <= pix_addr(src1, row_q, col_q);
                end
                S_WR: if (mem_ack) begin
                    mem_req_q <= 1'b0;
                    state_q <= S_NEXT;
                end else if (skip && !mem_req_q) begin
                    state_q <= S_NEXT;
                end else if (!mem_req_q) begin
                    mem_req_q <= 1'b1;
                    mem_cmd_q.we <= 1'b1;
                    mem_cmd_q.wdata <= res;
                    mem_cmd_q.addr <= pix_addr(dst, row_q, col_q);
                end
                S_NEXT: begin
                    if (col_q + 16'h0001 == win_w) begin
                        col_q <= 16'h0000;
                        row_q <= row_q + 16'h0001;
                    end else begin
                        col_q <= col_q + 16'h0001;
                    end
                    state_q <= last_px ? S_IDLE : first_state(op_q);
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_busy_status;
        busy_q |=> main_status_q[STS_BUSY_BIT] || $past(last_px);
    endproperty
    a_busy_status: assert property (p_busy_status)
        else $error("busy not shown in status");

    property p_busy_hold;
        busy_q && !last_px |=> busy_q && state_q != S_IDLE;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped before completion");

    property p_int_done;
        last_px |=> !int_n_q && done_flag_q && !busy_q;
    endproperty
    a_int_done: assert property (p_int_done)
        else $error("no interrupt on completion");

    property p_key_skip;
        state_q == S_WR && !mem_req_q && skip |=> state_q == S_NEXT
            && !mem_req_q;
    endproperty
    a_key_skip: assert property (p_key_skip)
        else $error("keyed pixel was written");

    property p_solid;
        $rose(mem_req_q) && mem_cmd_q.we && op_q == OP_SOLID
            |-> mem_cmd_q.wdata == fg;
    endproperty
    a_solid: assert property (p_solid)
        else $error("solid fill colour wrong");

    property p_rop_ends;
        $rose(mem_req_q) && mem_cmd_q.we && needs_s1(op_q)
            && !(op_q inside {OP_COPY_BLEND, OP_HOST_BLEND})
            && rop_q inside {4'h0, 4'hF}
            |-> mem_cmd_q.wdata == {24{rop_q[0]}};
    endproperty
    a_rop_ends: assert property (p_rop_ends)
        else $error("raster zero or one fill wrong");

    property p_rop_copy;
        $rose(mem_req_q) && mem_cmd_q.we && op_q == OP_COPY_ROP
            && rop_q == 4'hE |-> mem_cmd_q.wdata == (s0_q | s1_q);
    endproperty
    a_rop_copy: assert property (p_rop_copy)
        else $error("raster or result wrong");

    property p_host_only;
        host_ready_q |-> host_src(op_q) && busy_q;
    endproperty
    a_host_only: assert property (p_host_only)
        else $error("host data asked for a memory op");

    property p_expand;
        $rose(mem_req_q) && mem_cmd_q.we && op_q == OP_HOST_EXP
            |-> mem_cmd_q.wdata == (exp_cur_q ? fg : bg);
    endproperty
    a_expand: assert property (p_expand)
        else $error("expansion colour wrong");

endmodule : block_transfer_engine

// *** design/blit_pkg.sv ***
package blit_pkg;

    // register offsets
    localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CTRL_ZERO = 8'h90;
    localparam logic [7:0] OFS_OP_CTRL = 8'h91;
    localparam logic [7:0] OFS_FIRST_SOURCE = 8'h93;
    localparam logic [7:0] OFS_SECOND_SOURCE = 8'h9D;
    localparam logic [7:0] OFS_DESTINATION = 8'hA7;
    localparam logic [7:0] OFS_WIN_WIDTH = 8'hB1;
    localparam logic [7:0] OFS_WIN_HEIGHT = 8'hB3;
    localparam logic [7:0] OFS_FG_COLOUR = 8'hD2;
    localparam logic [7:0] OFS_BG_COLOUR = 8'hD5;
    localparam logic [7:0] OFS_ARRAY_LO = 8'h93;
    localparam logic [7:0] OFS_ARRAY_HI = 8'hD7;
    localparam int ARRAY_N = 69;

    // offsets inside a source or destination group
    localparam logic [7:0] GRP_ADDR = 8'h00;
    localparam logic [7:0] GRP_WIDTH = 8'h04;
    localparam logic [7:0] GRP_X = 8'h06;
    localparam logic [7:0] GRP_Y = 8'h08;

    // field positions
    localparam int CTRL_BUSY_BIT = 4;
    localparam int STS_BUSY_BIT = 3;
    localparam int INT_DONE_BIT = 1;
    localparam int OP_LSB = 0;
    localparam int RASTER_LSB = 4;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [23:0] RST_PIXEL = 24'h000000;

    localparam logic [3:0] EXP_LAST_WIDE = 4'hF;
    localparam logic [3:0] EXP_LAST_NARROW = 4'h7;

    typedef enum logic [3:0] {
        OP_HOST_ROP = 4'b0000,
        OP_COPY_ROP = 4'b0010,
        OP_HOST_KEY = 4'b0100,
        OP_COPY_KEY = 4'b0101,
        OP_PAT_ROP = 4'b0110,
        OP_PAT_KEY = 4'b0111,
        OP_HOST_EXP = 4'b1000,
        OP_HOST_EXPK = 4'b1001,
        OP_COPY_BLEND = 4'b1010,
        OP_HOST_BLEND = 4'b1011,
        OP_SOLID = 4'b1100,
        OP_COPY_EXP = 4'b1110,
        OP_COPY_EXPK = 4'b1111
    } op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HOST = 3'b001,
        S_RD0 = 3'b010,
        S_RD1 = 3'b011,
        S_WR = 3'b100,
        S_NEXT = 3'b101
    } state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] width;
        logic [15:0] x;
        logic [15:0] y;
    } block_t;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [23:0] wdata;
    } mem_cmd_t;

endpackage : blit_pkg

// *** design/raster_unit.sv ***
`timescale 1ns/1ns
module raster_unit (
    // operands and function code
    input wire logic [23:0] a,
    input wire logic [23:0] b,
    input wire logic [3:0] code,
    // result
    output logic [23:0] y
);
    // each bit indexes the code with {a,b}
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            y[i] = code[{a[i], b[i]}];
        end
    end
endmodule : raster_unit

// *** tb/display_mem_model.sv ***
`timescale 1ns/1ns
module display_mem_model
    import blit_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // request side
    input wire logic mem_req_q,
    input wire mem_cmd_t mem_cmd_q,
    // answer side
    output logic mem_ack,
    output logic [23:0] mem_rdata
);
    logic [23:0] store [256];
    logic [23:0] rd_q;
    logic [1:0] cnt_q;
    logic hold_q;
    logic slow_q;

    initial begin
        for (int i = 0; i < 256; i++) begin
            store[i] = {8'h5A, i[7:0], ~i[7:0]};
        end
    end

    // released data line shows the inverse, never the last value
    assign mem_rdata = mem_ack ? rd_q : ~rd_q;

    // answers alternate between prompt and slow
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            cnt_q <= 2'd0;
            hold_q <= 1'b0;
            slow_q <= 1'b0;
            rd_q <= 24'h000000;
        end else begin
            mem_ack <= 1'b0;
            if (!mem_req_q) begin
                hold_q <= 1'b0;
                cnt_q <= 2'd0;
            end else if (!hold_q) begin
                if (cnt_q == (slow_q ? 2'd3 : 2'd1)) begin
                    mem_ack <= 1'b1;
                    hold_q <= 1'b1;
                    cnt_q <= 2'd0;
                    slow_q <= ~slow_q;
                    if (mem_cmd_q.we) begin
                        store[mem_cmd_q.addr[7:0]] <= mem_cmd_q.wdata;
                    end else begin
                        rd_q <= store[mem_cmd_q.addr[7:0]];
                    end
                end else begin
                    cnt_q <= cnt_q + 2'd1;
                end
            end
        end
    end
endmodule : display_mem_model

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    import blit_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd, host_bus_16, host_pix_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, main_status_q, rv;
    logic [23:0] host_pix_data, mem_rdata;
    logic host_ready_q, mem_req_q, mem_ack, int_n_q;
    mem_cmd_t mem_cmd_q;
    int n_fail, num_checks;
    localparam logic [23:0] FG = 24'hE01C3B;
    localparam logic [23:0] BG = 24'h12AB7F;
    localparam logic [23:0] PA = 24'hF0CC33;
    localparam logic [23:0] PB = 24'h0FAA35;

    block_transfer_engine dut (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .host_bus_16(host_bus_16), .host_pix_valid(host_pix_valid),
        .host_pix_data(host_pix_data), .host_ready_q(host_ready_q),
        .mem_req_q(mem_req_q), .mem_cmd_q(mem_cmd_q), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .main_status_q(main_status_q),
        .int_n_q(int_n_q));
    display_mem_model mem (.clk_sys(clk_sys), .rst(rst),
        .mem_req_q(mem_req_q), .mem_cmd_q(mem_cmd_q), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk_reg(string nm, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_pix(string nm, logic [23:0] e, logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pix

    task automatic chk_bit(string nm, logic e, logic g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        @(negedge clk_sys);
        v = reg_rdata_q;
    endtask : rd

    task automatic set_blk(logic [7:0] ofs, logic [31:0] adr,
                           logic [15:0] x, logic [15:0] y);
        logic [79:0] v;
        v = {y, x, 16'h0010, adr};
        for (int i = 0; i < 10; i++) wr(ofs + 8'(i), v[i*8 +: 8]);
    endtask : set_blk

    task automatic set_win(logic [7:0] w, logic [7:0] h);
        wr(OFS_WIN_WIDTH, w);
        wr(OFS_WIN_WIDTH + 8'h01, 8'h00);
        wr(OFS_WIN_HEIGHT, h);
        wr(OFS_WIN_HEIGHT + 8'h01, 8'h00);
    endtask : set_win

    task automatic set_col(logic [7:0] ofs, logic [23:0] c);
        wr(ofs, c[23:16]);
        wr(ofs + 8'h01, c[15:8]);
        wr(ofs + 8'h02, c[7:0]);
    endtask : set_col

    task automatic start(logic [3:0] op, logic [3:0] fn);
        wr(OFS_OP_CTRL, {fn, op});
        wr(OFS_CTRL_ZERO, 8'h10);
    endtask : start

    task automatic host_send(logic [23:0] d);
        @(negedge clk_sys);
        host_pix_valid = 1'b1;
        host_pix_data = d;
        for (int i = 0; i < 400 && host_ready_q !== 1'b1; i++)
            @(negedge clk_sys);
        @(negedge clk_sys);
        host_pix_valid = 1'b0;
        host_pix_data = ~d;
    endtask : host_send

    // host waits for completion before touching settings again
    task automatic finish_op();
        for (int i = 0; i < 400 && int_n_q !== 1'b0; i++)
            @(negedge clk_sys);
        chk_bit("int_n", 1'b0, int_n_q);
        chk_bit("status busy", 1'b0, main_status_q[STS_BUSY_BIT]);
        rd(OFS_CTRL_ZERO, rv);
        chk_bit("ctrl busy", 1'b0, rv[CTRL_BUSY_BIT]);
        rd(OFS_INT_STATUS, rv);
        chk_bit("done flag", 1'b1, rv[INT_DONE_BIT]);
        wr(OFS_INT_STATUS, 8'h02);
        @(negedge clk_sys);
        chk_bit("int_n cleared", 1'b1, int_n_q);
    endtask : finish_op

    // truth table of the function code indexed by {a, b}
    function automatic logic [23:0] raster_logic_function(logic [3:0] c, logic [23:0] a,
                                        logic [23:0] b);
        for (int i = 0; i < 24; i++) raster_logic_function[i] = c[{a[i], b[i]}];
    endfunction : raster_logic_function

    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, host_pix_valid, host_bus_16} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        host_pix_data = 24'h000000;
        n_fail = 0;
        num_checks = 0;
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        chk_bit("int_n reset", 1'b1, int_n_q);
        chk_reg("status reset", 8'h00, main_status_q);
        chk_bit("mem_req reset", 1'b0, mem_req_q);
        rd(OFS_OP_CTRL, rv);
        chk_reg("op ctrl reset", 8'h00, rv);
        wr(OFS_OP_CTRL, 8'hC2);
        rd(OFS_OP_CTRL, rv);
        chk_reg("op ctrl", 8'hC2, rv);
        wr(8'h50, 8'hFF);
        rd(8'h50, rv);
        chk_reg("unmapped", 8'h00, rv);
        set_col(OFS_FG_COLOUR, FG);
        set_col(OFS_BG_COLOUR, BG);
        rd(OFS_BG_COLOUR, rv);
        chk_reg("bg red", BG[23:16], rv);
        set_blk(OFS_FIRST_SOURCE, 32'h10, 16'h0, 16'h0);
        set_blk(OFS_SECOND_SOURCE, 32'h20, 16'h0, 16'h0);
        set_blk(OFS_DESTINATION, 32'h30, 16'h0, 16'h0);
        set_win(8'h01, 8'h01);
        mem.store[8'h10] = PA;
        mem.store[8'h20] = PB;
        for (int c = 0; c < 16; c++) begin
            wr(OFS_DESTINATION + GRP_X, 8'(c));
            start(OP_COPY_ROP, 4'(c));
            finish_op();
            chk_pix("copy raster", raster_logic_function(4'(c), PA, PB),
                    mem.store[8'h30 + c]);
        end
        set_blk(OFS_DESTINATION, 32'h40, 16'h0, 16'h0);
        set_win(8'h02, 8'h01);
        start(OP_HOST_ROP, 4'hC);
        host_send(24'h111111);
        host_send(24'h222222);
        finish_op();
        chk_pix("host raster 0", 24'h111111, mem.store[8'h40]);
        chk_pix("host raster 1", 24'h222222, mem.store[8'h41]);
        start(OP_HOST_KEY, 4'h0);
        host_send(BG);
        host_send(24'h333333);
        finish_op();
        chk_pix("keyed skip", 24'h111111, mem.store[8'h40]);
        chk_pix("keyed write", 24'h333333, mem.store[8'h41]);
        host_bus_16 = 1'b1;
        set_blk(OFS_DESTINATION, 32'h50, 16'h0, 16'h0);
        set_win(8'h04, 8'h01);
        start(OP_HOST_EXP, 4'd14);
        host_send(24'h004000);
        host_send(24'h008000);
        finish_op();
        chk_pix("expand 0", FG, mem.store[8'h50]);
        chk_pix("expand 1", BG, mem.store[8'h51]);
        chk_pix("expand 2", BG, mem.store[8'h52]);
        chk_pix("expand 3", FG, mem.store[8'h53]);
        host_bus_16 = 1'b0;
        start(OP_HOST_EXP, 4'd6);
        host_send(24'h0001C0);
        host_send(24'h000080);
        finish_op();
        chk_pix("narrow", BG, mem.store[8'h52]);
        set_blk(OFS_DESTINATION, 32'h60, 16'h1, 16'h1);
        set_win(8'h02, 8'h02);
        start(OP_SOLID, 4'h0);
        @(negedge clk_sys);
        chk_bit("busy status", 1'b1, main_status_q[STS_BUSY_BIT]);
        rd(OFS_CTRL_ZERO, rv);
        chk_bit("busy ctrl", 1'b1, rv[CTRL_BUSY_BIT]);
        finish_op();
        chk_pix("solid a", FG, mem.store[8'h71]);
        chk_pix("solid b", FG, mem.store[8'h72]);
        chk_pix("solid c", FG, mem.store[8'h81]);
        chk_pix("solid d", FG, mem.store[8'h82]);
        chk_pix("solid edge", 24'h5A738C, mem.store[8'h73]);
        start(OP_COPY_BLEND, 4'h0);
        finish_op();
        chk_pix("blend", 24'h7FBB34, mem.store[8'h71]);
        start(4'b0001, 4'h0);
        repeat (3) begin
            @(negedge clk_sys);
            chk_bit("reserved idle", 1'b0,
                    main_status_q[STS_BUSY_BIT]);
        end
        finish_op();
        conclude();
    end
endmodule : testbench
